// File: hdl/msp_map.vh
// constants for the four-port serial peripheral block
`ifndef MSP_MAP_VH
`define MSP_MAP_VH
// ----------------------------------------------------------------
// clock rates and serial clock ceilings, in MHz
// ----------------------------------------------------------------
`define MSP_REF_MHZ 100
`define MSP_MEM_MAX_MHZ 120
`define MSP_GP_SDR_MAX_MHZ 80
`define MSP_GP_DDR_MAX_MHZ 40
`define MSP_SLV_MAX_MHZ 60
// least half-period divider so that ref/(2*(div+1)) stays at or below the ceiling
`define MSP_DIV_MIN(mhz) ((`MSP_REF_MHZ + 2 * (mhz) - 1) / (2 * (mhz)) - 1)
// ----------------------------------------------------------------
// register map: byte offsets inside one port window
// ----------------------------------------------------------------
`define MSP_PORT_STRIDE 8'h20
`define MSP_REG_CTRL 5'h00
`define MSP_REG_DIV 5'h04
`define MSP_REG_TXD 5'h08
`define MSP_REG_RXD 5'h0C
`define MSP_REG_STAT 5'h10
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define MSP_CTRL_EN 0
`define MSP_CTRL_SLAVE 1
`define MSP_CTRL_LINES_LO 2
`define MSP_CTRL_LINES_HI 3
`define MSP_CTRL_DDR 4
`define MSP_CTRL_CPOL 5
`define MSP_CTRL_CPHA 6
`define MSP_CTRL_FDX 7
`define MSP_CTRL_DMA 8
`define MSP_CTRL_RXDIR 9
// ----------------------------------------------------------------
// status fields and reset values
// ----------------------------------------------------------------
`define MSP_STAT_BUSY 0
`define MSP_STAT_TXEMPTY 1
`define MSP_STAT_TXFULL 2
`define MSP_STAT_RXFULL 3
`define MSP_STAT_RXOVR 4
`define MSP_CTRL_RST 10'h000
`define MSP_DIV_RST 8'h03
`define MSP_FIFO_DEPTH 8
`define MSP_FIFO_AW 3
`endif

// File: hdl/msp_spi_ports.v
// four serial peripheral ports with apb registers and tx fifos, dma streams on the two general ports
`timescale 1ns/100ps
`include "msp_map.vh"
// Contract
// [RULE1] memory ports move bytes, eight lines, sdr/ddr
// [RULE2] memory port clock up to 120 MHz
// [RULE3] port a master: full duplex, 1/2/4/8-line half
// [RULE4] port a slave: full duplex, 1/2/4-line half
// [RULE5] general ports: clock polarity and phase configurable
// [RULE6] general ports move whole bytes only
// [RULE7] port a full duplex: 80/60 MHz, sdr
// [RULE8] port a half duplex master: 80 sdr, 40 ddr
// [RULE9] port a half duplex slave: sdr, 60 MHz
// [RULE10] port b: master/slave, up to four lines, sdr
// [RULE11] port b clock: master 80, slave 60 MHz
// [RULE12] general ports move data by dma

// ----------------------------------------------------------------
// fifo
// ----------------------------------------------------------------
module msp_fifo #(
    parameter W = 8,
    parameter D = `MSP_FIFO_DEPTH,
    parameter AW = `MSP_FIFO_AW
) (
    input wire ref_clk,
    input wire rst,
    input wire in_valid,
    input wire [W-1:0] in_data,
    output wire in_ready,
    output wire out_valid,
    output wire [W-1:0] out_data,
    input wire out_ready
);
    reg [W-1:0] mem_r [0:D-1];
    reg [AW-1:0] wi_r;
    reg [AW-1:0] ri_r;
    reg [AW:0] cnt_r;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    assign in_ready = (cnt_r != D);
    assign out_valid = (cnt_r != 0);
    assign out_data = mem_r[ri_r];
    always @(posedge ref_clk) begin
        if (push) begin
            mem_r[wi_r] <= in_data;
        end
    end
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wi_r <= {AW{1'b0}};
            ri_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wi_r <= (wi_r == D - 1) ? {AW{1'b0}} : wi_r + 1'b1;
            end
            if (pop) begin
                ri_r <= (ri_r == D - 1) ? {AW{1'b0}} : ri_r + 1'b1;
            end
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // msp_fifo

// ----------------------------------------------------------------
// one port engine
// ----------------------------------------------------------------
module msp_port #(
    parameter [1:0] MAXL = 2'd3,
    parameter CAN_SLAVE = 0,
    parameter CAN_DDR = 1,
    parameter CAN_DMA = 0,
    parameter [7:0] DIV_SDR = 8'h00,
    parameter [7:0] DIV_DDR = 8'h00
) (
    input wire ref_clk,
    input wire rst,
    input wire wr_en,
    input wire rd_done,
    input wire [4:0] reg_sel,
    input wire [31:0] wdata,
    output reg [31:0] rdata,
    output wire wr_err,
    input wire sclk_i,
    input wire cs_n_i,
    input wire [7:0] dq_i,
    output wire sclk_o,
    output wire sclk_oe_n,
    output wire cs_n_o,
    output wire cs_n_oe_n,
    output wire [7:0] dq_o,
    output wire [7:0] dq_oe_n,
    input wire dma_tx_valid,
    input wire [7:0] dma_tx_data,
    output wire dma_tx_ready,
    output wire dma_rx_valid,
    output wire [7:0] dma_rx_data,
    input wire dma_rx_ready
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_RUN = 3'b010;
    localparam [2:0] ST_END = 3'b100;

    function [7:0] top_of;
        input [7:0] x;
        input [1:0] l;
        begin
            case (l)
                2'd0: top_of = {7'h00, x[7]};
                2'd1: top_of = {6'h00, x[7:6]};
                2'd2: top_of = {4'h0, x[7:4]};
                default: top_of = x;
            endcase
        end
    endfunction

    reg [9:0] ctrl_r;
    reg [7:0] div_r;
    reg [2:0] st_r;
    reg [7:0] divc_r;
    reg [4:0] ecnt_r;
    reg sclk_r;
    reg cs_r;
    reg [7:0] tx_sh_r;
    reg [7:0] out_r;
    reg [7:0] rx_sh_r;
    reg [7:0] rx_r;
    reg rxf_r;
    reg ovr_r;
    reg sck_s1_r, sck_s2_r, sck_s3_r;
    reg cs_s1_r, cs_s2_r, cs_s3_r;
    reg [7:0] dq_s1_r, dq_s2_r;

    // ----------------------------------------------------------------
    // effective configuration, clamped to what this port can do
    // ----------------------------------------------------------------
    wire en = ctrl_r[`MSP_CTRL_EN];
    wire slv = ctrl_r[`MSP_CTRL_SLAVE] & (CAN_SLAVE != 0); // [RULE4] [RULE10]
    wire fdx = ctrl_r[`MSP_CTRL_FDX];
    wire cpol = ctrl_r[`MSP_CTRL_CPOL]; // [RULE5]
    wire cpha = ctrl_r[`MSP_CTRL_CPHA]; // [RULE5]
    wire rxdir = ctrl_r[`MSP_CTRL_RXDIR];
    wire dma = ctrl_r[`MSP_CTRL_DMA] & (CAN_DMA != 0); // [RULE12]
    // full duplex is two lines, one each way; a slave never offers eight lines
    wire [1:0] lim = fdx ? 2'd0 : ((slv && MAXL > 2'd2) ? 2'd2 : MAXL); // [RULE3] [RULE4] [RULE10]
    wire [1:0] raw_l = ctrl_r[`MSP_CTRL_LINES_HI:`MSP_CTRL_LINES_LO];
    wire [1:0] ln = (raw_l > lim) ? lim : raw_l; // [RULE1]
    wire ddr = ctrl_r[`MSP_CTRL_DDR] & (CAN_DDR != 0) & ~slv & ~fdx; // [RULE7] [RULE9] [RULE10]
    wire [7:0] dmin = ddr ? DIV_DDR : DIV_SDR;
    wire [7:0] dv = (div_r < dmin) ? dmin : div_r; // [RULE2] [RULE7] [RULE8] [RULE11]
    // edges per byte: a master byte is cut short only when ctrl is rewritten in mid-frame, clearing en, setting slave or changing lines or ddr
    wire [4:0] elast = ddr ? ((5'd8 >> ln) - 5'd1) : ((5'd16 >> ln) - 5'd1); // [RULE6]

    // ----------------------------------------------------------------
    // edge strobes, shared by master and slave datapath
    // ----------------------------------------------------------------
    wire fifo_ov;
    wire fifo_ir;
    wire [7:0] fifo_od;
    wire tick = (st_r != ST_IDLE) && (divc_r == 8'h00);
    wire m_edge = (st_r == ST_RUN) && tick;
    wire s_act = en & slv & ~cs_s2_r;
    wire s_edge = s_act & (sck_s2_r ^ sck_s3_r);
    wire tog = slv ? s_edge : m_edge;
    wire lead = slv ? (sck_s3_r == cpol) : (sclk_r == cpol);
    wire smp = tog & (ddr | (lead ^ cpha)); // [RULE5]
    wire shf = tog & (ddr | ~(lead ^ cpha)); // [RULE5]
    wire last = tog & (ecnt_r == elast); // [RULE6]
    wire start = slv ? (en & cs_s3_r & ~cs_s2_r) : (en & (st_r == ST_IDLE) & fifo_ov);
    wire load = start | (last & (slv | fifo_ov));
    wire pop = load & fifo_ov;
    wire [7:0] nbyte = fifo_ov ? fifo_od : 8'h00;
    wire present = ~cpha | ddr;
    // slave full duplex takes its data on line zero, master on line one
    wire din1 = (fdx & ~slv) ? dq_s2_r[1] : dq_s2_r[0];
    reg [7:0] rxn;
    always @* begin
        case (ln)
            2'd0: rxn = {rx_sh_r[6:0], din1};
            2'd1: rxn = {rx_sh_r[5:0], dq_s2_r[1:0]};
            2'd2: rxn = {rx_sh_r[3:0], dq_s2_r[3:0]};
            default: rxn = dq_s2_r;
        endcase
    end
    wire [7:0] wmask = (ln == 2'd0) ? 8'h01 : (ln == 2'd1) ? 8'h03 : (ln == 2'd2) ? 8'h0F : 8'hFF;
    wire active = slv ? s_act : (st_r != ST_IDLE);
    wire [7:0] drive = ~active ? 8'h00 : fdx ? (slv ? 8'h02 : 8'h01) : (rxdir ? 8'h00 : wmask); // [RULE3]

    // ----------------------------------------------------------------
    // pins
    // ----------------------------------------------------------------
    assign sclk_o = sclk_r;
    assign sclk_oe_n = ~(en & ~slv);
    assign cs_n_o = cs_r;
    assign cs_n_oe_n = ~(en & ~slv);
    assign dq_o = (fdx & slv) ? {6'h00, out_r[0], 1'b0} : out_r;
    assign dq_oe_n = ~drive;

    // ----------------------------------------------------------------
    // tx fifo: fed by software or by dma, never both
    // ----------------------------------------------------------------
    wire sw_tx = wr_en & (reg_sel == `MSP_REG_TXD);
    assign wr_err = (reg_sel == `MSP_REG_TXD) & (dma | ~fifo_ir);
    assign dma_tx_ready = dma & fifo_ir; // [RULE12]
    assign dma_rx_valid = dma & rxf_r; // [RULE12]
    assign dma_rx_data = rx_r;
    msp_fifo #(.W(8), .D(`MSP_FIFO_DEPTH), .AW(`MSP_FIFO_AW)) u_txq (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(dma ? dma_tx_valid : (sw_tx & ~dma)),
        .in_data(dma ? dma_tx_data : wdata[7:0]),
        .in_ready(fifo_ir),
        .out_valid(fifo_ov),
        .out_data(fifo_od),
        .out_ready(pop)
    );

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    wire rx_clr = (rd_done & (reg_sel == `MSP_REG_RXD)) | (dma_rx_valid & dma_rx_ready);
    always @* begin
        case (reg_sel)
            `MSP_REG_CTRL: rdata = {22'h000000, ctrl_r};
            `MSP_REG_DIV: rdata = {24'h000000, div_r};
            `MSP_REG_RXD: rdata = {24'h000000, rx_r};
            `MSP_REG_STAT: rdata = {27'h0000000, ovr_r, rxf_r, ~fifo_ir, ~fifo_ov, active};
            default: rdata = 32'h00000000;
        endcase
    end

    // ----------------------------------------------------------------
    // pin synchronisers: data lines pass two flops, clock and select pass three
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_s3_r <= 1'b0;
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
            dq_s1_r <= 8'h00;
            dq_s2_r <= 8'h00;
        end else begin
            sck_s1_r <= sclk_i;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            cs_s1_r <= cs_n_i;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
            dq_s1_r <= dq_i;
            dq_s2_r <= dq_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // master sequencer and edge counter
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= `MSP_CTRL_RST;
            div_r <= `MSP_DIV_RST;
            st_r <= ST_IDLE;
            divc_r <= 8'h00;
            ecnt_r <= 5'h00;
            sclk_r <= 1'b0;
            cs_r <= 1'b1;
        end else begin
            if (wr_en && reg_sel == `MSP_REG_CTRL) begin
                ctrl_r <= wdata[9:0];
            end
            if (wr_en && reg_sel == `MSP_REG_DIV) begin
                div_r <= wdata[7:0];
            end
            if (slv) begin
                st_r <= ST_IDLE;
                cs_r <= 1'b1;
                sclk_r <= cpol;
                if (cs_s2_r) begin
                    ecnt_r <= 5'h00;
                end else if (tog) begin
                    ecnt_r <= last ? 5'h00 : ecnt_r + 5'h01;
                end
            end else begin
                case (st_r)
                    ST_IDLE: begin
                        sclk_r <= cpol;
                        if (start) begin
                            cs_r <= 1'b0;
                            st_r <= ST_RUN;
                            divc_r <= dv;
                            ecnt_r <= 5'h00;
                        end
                    end
                    ST_RUN: begin
                        if (!en) begin
                            st_r <= ST_IDLE;
                            cs_r <= 1'b1;
                        end else if (tick) begin
                            divc_r <= dv;
                            sclk_r <= ~sclk_r;
                            ecnt_r <= last ? 5'h00 : ecnt_r + 5'h01;
                            // chip select stays low while more bytes wait
                            if (last && !fifo_ov) begin
                                st_r <= ST_END;
                            end
                        end else begin
                            divc_r <= divc_r - 8'h01;
                        end
                    end
                    ST_END: begin
                        // eight-line ddr takes one edge per byte, so an odd byte count leaves the clock off idle; bring it home first
                        if (tick) begin
                            divc_r <= dv;
                            if (sclk_r != cpol) begin
                                sclk_r <= cpol;
                            end else begin
                                cs_r <= 1'b1;
                                st_r <= ST_IDLE;
                            end
                        end else begin
                            divc_r <= divc_r - 8'h01;
                        end
                    end
                    default: begin
                        st_r <= ST_IDLE;
                        cs_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // shift datapath
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_sh_r <= 8'h00;
            out_r <= 8'h00;
            rx_sh_r <= 8'h00;
            rx_r <= 8'h00;
            rxf_r <= 1'b0;
            ovr_r <= 1'b0;
        end else begin
            if (smp) begin
                rx_sh_r <= rxn;
            end
            if (shf) begin
                out_r <= top_of(tx_sh_r, ln);
                tx_sh_r <= tx_sh_r << (4'd1 << ln);
            end
            if (load) begin
                if (present) begin
                    out_r <= top_of(nbyte, ln);
                    tx_sh_r <= nbyte << (4'd1 << ln);
                end else begin
                    tx_sh_r <= nbyte;
                end
            end
            // clear first so that a byte landing in the same cycle wins
            if (rx_clr) begin
                rxf_r <= 1'b0;
                ovr_r <= 1'b0;
            end
            if (last) begin
                rx_r <= smp ? rxn : rx_sh_r; // [RULE6]
                rxf_r <= 1'b1;
                if (rxf_r && !rx_clr) begin
                    ovr_r <= 1'b1;
                end
            end
        end
    end
endmodule // msp_port

// ----------------------------------------------------------------
// top: apb slave and four ports
// ----------------------------------------------------------------
module msp_spi_ports (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [3:0] sclk_i,
    input wire [3:0] cs_n_i,
    input wire [31:0] dq_i,
    output wire [3:0] sclk_o,
    output wire [3:0] sclk_oe_n,
    output wire [3:0] cs_n_o,
    output wire [3:0] cs_n_oe_n,
    output wire [31:0] dq_o,
    output wire [31:0] dq_oe_n,
    input wire [3:0] dma_tx_valid,
    input wire [31:0] dma_tx_data,
    output wire [3:0] dma_tx_ready,
    output wire [3:0] dma_rx_valid,
    output wire [31:0] dma_rx_data,
    input wire [3:0] dma_rx_ready
);
    reg pready_r;
    reg pslverr_r;
    reg [31:0] prdata_r;
    wire [127:0] rd_all;
    wire [3:0] err_all;
    wire [1:0] psel_port = paddr[6:5];
    // one wait state so that read data leaves a flop
    wire acc = psel & penable & ~pready_r;
    wire done = psel & penable & pready_r & ~pslverr_r;
    wire bad = paddr[7] | (paddr[1:0] != 2'b00) | (paddr[4:0] > `MSP_REG_STAT);
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign prdata = prdata_r;

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= acc;
            if (acc) begin
                pslverr_r <= bad | (pwrite & err_all[psel_port]);
                prdata_r <= (pwrite | bad) ? 32'h00000000 : rd_all[psel_port * 32 +: 32];
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_port
            localparam [1:0] MAXL = (i == 3) ? 2'd2 : 2'd3; // [RULE1] [RULE3] [RULE10]
            localparam [7:0] DSDR = (i < 2) ? `MSP_DIV_MIN(`MSP_MEM_MAX_MHZ) : `MSP_DIV_MIN(`MSP_GP_SDR_MAX_MHZ); // [RULE2] [RULE7] [RULE8] [RULE11]
            localparam [7:0] DDDR = (i < 2) ? `MSP_DIV_MIN(`MSP_MEM_MAX_MHZ) : `MSP_DIV_MIN(`MSP_GP_DDR_MAX_MHZ); // [RULE2] [RULE8]
            msp_port #(
                .MAXL(MAXL),
                .CAN_SLAVE(i >= 2),
                .CAN_DDR(i < 3),
                .CAN_DMA(i >= 2),
                .DIV_SDR(DSDR),
                .DIV_DDR(DDDR)
            ) u_port (
                .ref_clk(ref_clk),
                .rst(rst),
                .wr_en(done & pwrite & (psel_port == i)),
                .rd_done(done & ~pwrite & (psel_port == i)),
                .reg_sel(paddr[4:0]),
                .wdata(pwdata),
                .rdata(rd_all[i*32 +: 32]),
                .wr_err(err_all[i]),
                .sclk_i(sclk_i[i]),
                .cs_n_i(cs_n_i[i]),
                .dq_i(dq_i[i*8 +: 8]),
                .sclk_o(sclk_o[i]),
                .sclk_oe_n(sclk_oe_n[i]),
                .cs_n_o(cs_n_o[i]),
                .cs_n_oe_n(cs_n_oe_n[i]),
                .dq_o(dq_o[i*8 +: 8]),
                .dq_oe_n(dq_oe_n[i*8 +: 8]),
                .dma_tx_valid(dma_tx_valid[i]),
                .dma_tx_data(dma_tx_data[i*8 +: 8]),
                .dma_tx_ready(dma_tx_ready[i]),
                .dma_rx_valid(dma_rx_valid[i]),
                .dma_rx_data(dma_rx_data[i*8 +: 8]),
                .dma_rx_ready(dma_rx_ready[i])
            );
        end
    endgenerate
endmodule // msp_spi_ports

// File: tb/msp_dev_model.sv
// behavioural single-line device on the far side of port a
`timescale 1ns/100ps
module msp_dev_model (
    input wire sclk,
    input wire cs_n,
    input wire mosi,
    input wire cpol,
    input wire cpha,
    input wire [7:0] tx_byte,
    output wire miso,
    output reg [7:0] rx_byte
);
    reg [7:0] sh = 8'h00;
    reg b = 1'b0;
    wire s = sclk ^ cpol;
    // released line shows the inverse so a stale bit never passes
    assign miso = cs_n ? ~b : b;
    always @(negedge cs_n) begin
        sh = tx_byte;
        if (!cpha) begin
            b = sh[7];
            sh = sh << 1;
        end
    end
    // one bit per clock period, single data rate only
    always @(posedge s) begin
        if (!cs_n && cpha) begin
            b = sh[7];
            sh = sh << 1;
        end else if (!cs_n) begin
            rx_byte = {rx_byte[6:0], mosi};
        end
    end
    always @(negedge s) begin
        if (!cs_n && !cpha) begin
            b = sh[7];
            sh = sh << 1;
        end else if (!cs_n) begin
            rx_byte = {rx_byte[6:0], mosi};
        end
    end
endmodule // msp_dev_model

// File: tb/msp_spi_ports_chk.sv
// assertion checker for the four-port serial block
`timescale 1ns/100ps
module msp_spi_ports_chk (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire [3:0] sclk_o,
    input wire [3:0] sclk_oe_n,
    input wire [3:0] cs_n_o,
    input wire [3:0] cs_n_oe_n,
    input wire [31:0] dq_oe_n,
    input wire [3:0] dma_tx_ready,
    input wire [3:0] dma_rx_valid
);
    // ----------------------------------------------------------------
    // clock edge counts inside one frame
    // ----------------------------------------------------------------
    reg [3:0] sclk_q_r;
    reg [7:0] cnt0_r, cnt2_r;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sclk_q_r <= 4'h0;
            cnt0_r <= 8'h00;
            cnt2_r <= 8'h00;
        end else begin
            sclk_q_r <= sclk_o;
            cnt0_r <= cs_n_o[0] ? 8'h00 : cnt0_r + {7'h00, sclk_o[0] ^ sclk_q_r[0]};
            cnt2_r <= cs_n_o[2] ? 8'h00 : cnt2_r + {7'h00, sclk_o[2] ^ sclk_q_r[2]};
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_rdy_pulse; pready |=> !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
    property p_rdy_wait; psel && penable && !$past(penable) |-> !pready ##1 pready; endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("access phase not two cycles");
    property p_err_rdy; pslverr |-> pready; endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
    property p_oe_pair; sclk_oe_n == cs_n_oe_n; endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("clock and select enables differ");
    property p_mem_dma; (dma_tx_ready[1:0] | dma_rx_valid[1:0]) == 2'h0; endproperty
    a_mem_dma: assert property (p_mem_dma) else $error("memory port offers dma");
    property p_b_lines; dq_oe_n[31:28] == 4'hF; endproperty
    a_b_lines: assert property (p_b_lines) else $error("port b drives upper lines");
    property p_a_slave; sclk_oe_n[2] |-> dq_oe_n[23:20] == 4'hF; endproperty
    a_a_slave: assert property (p_a_slave) else $error("port a upper lines driven off master");
    property p_mem_bytes; $rose(cs_n_o[0]) |-> !cnt0_r[0] && cnt0_r != 8'h00; endproperty
    a_mem_bytes: assert property (p_mem_bytes) else $error("memory frame not whole");
    property p_gp_bytes; $rose(cs_n_o[2]) |-> !cnt2_r[0] && cnt2_r != 8'h00; endproperty
    a_gp_bytes: assert property (p_gp_bytes) else $error("port a frame not whole");
endmodule // msp_spi_ports_chk
bind msp_spi_ports msp_spi_ports_chk chk_u (.ref_clk, .rst, .psel, .penable, .pready, .pslverr, .sclk_o,
    .sclk_oe_n, .cs_n_o, .cs_n_oe_n, .dq_oe_n, .dma_tx_ready, .dma_rx_valid);

// File: tb/tb_top.sv
// self-checking bench for the four-port serial block
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
    $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
`define WAITQ(c) begin i = 0; do begin @(posedge ref_clk); i++; end while (!(c) && i < 500); \
    if (!(c)) begin miscompares++; results; end end
module tb_top;
    reg ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg [7:0] paddr = 8'h00, mtx = 8'h00, rb, sb = 8'hB4;
    reg [31:0] pwdata = 32'h0, dma_tx_data = 32'h0, rq;
    reg [3:0] dma_tx_valid = 4'h0, dma_rx_ready = 4'h0;
    reg slv = 1'b0, tsclk = 1'b0, tcs = 1'b1, mosi = 1'b0, mcpol = 1'b0, mcpha = 1'b0, re;
    reg [15:0] snf = 16'h0;
    integer i, k, m, checks_done = 0, miscompares = 0;
    wire [31:0] prdata, dq_o, dq_oe_n, dq_i, dma_rx_data;
    wire [3:0] sclk_o, sclk_oe_n, cs_n_o, cs_n_oe_n, dma_tx_ready, dma_rx_valid, sclk_i, cs_n_i;
    wire pready, pslverr, miso;
    wire [7:0] mrx;
    // ----------------------------------------------------------------
    // wiring, far side and link master
    // ----------------------------------------------------------------
    assign sclk_i = {slv ? tsclk : sclk_o[3], sclk_o[2:0]};
    assign cs_n_i = {slv ? tcs : cs_n_o[3], cs_n_o[2:0]};
    assign dq_i = {dq_o[31:25], slv ? mosi : dq_o[24], dq_o[23:18], miso, dq_o[16:0]};
    always #5 ref_clk = ~ref_clk;
    always @(posedge sclk_o[3]) if (!cs_n_o[3]) snf <= {snf[11:0], dq_o[27:24]};
    msp_spi_ports dut_u (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .sclk_i, .cs_n_i, .dq_i, .sclk_o, .sclk_oe_n, .cs_n_o, .cs_n_oe_n, .dq_o, .dq_oe_n,
        .dma_tx_valid, .dma_tx_data, .dma_tx_ready, .dma_rx_valid, .dma_rx_data, .dma_rx_ready);
    msp_dev_model dev_u (.sclk(sclk_o[2]), .cs_n(cs_n_o[2]), .mosi(dq_o[16]), .cpol(mcpol), .cpha(mcpha),
        .tx_byte(mtx), .miso(miso), .rx_byte(mrx));
    task results;
        begin
            $display("checks_done %0d miscompares %0d", checks_done, miscompares);
            if (miscompares == 0 && checks_done > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // one bus cycle; an idle edge follows so psel is never set twice in one step
    task apb(input reg w, input reg [7:0] a, input reg [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge ref_clk);
            penable <= 1'b1;
            `WAITQ(pready)
            rq = prdata;
            re = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge ref_clk);
        end
    endtask
    task idle(input reg [7:0] b);
        begin
            k = 0;
            do begin
                apb(0, b + 8'h10, 0);
                k++;
            end while (rq[1:0] !== 2'b10 && k < 200);
            `CHK(rq[1:0], 2'b10)
            if (rq[1:0] !== 2'b10) results;
        end
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (m = 0; m < 4; m++) begin
            apb(0, {m[2:0], 5'h00}, 0);
            `CHK(rq, 32'h0)
            apb(0, {m[2:0], 5'h04}, 0);
            `CHK(rq, 32'h3)
            apb(0, {m[2:0], 5'h10}, 0);
            `CHK(rq, 32'h2)
        end
        apb(0, 8'h14, 0);
        `CHK({re, rq}, 33'h100000000)
        apb(1, 8'h82, 32'h1);
        `CHK(re, 1'b1)
        $display("reset and map test done");
        apb(1, 8'h44, 32'h3);
        for (m = 0; m < 4; m++) begin
            apb(1, 8'h40, {24'h0, 1'b1, m[1:0], 5'h01});
            mcpol <= m[0];
            mcpha <= m[1];
            mtx <= 8'h3C + m[7:0];
            apb(1, 8'h48, {24'h0, 8'hA5 ^ m[7:0]});
            idle(8'h40);
            apb(0, 8'h4C, 0);
            `CHK(rq, {24'h0, 8'h3C + m[7:0]})
            `CHK(mrx, 8'hA5 ^ m[7:0])
        end
        $display("port a clock format test done");
        apb(1, 8'h40, 32'h181);
        mcpol <= 1'b0;
        mcpha <= 1'b0;
        mtx <= 8'h69;
        apb(1, 8'h48, 32'h11);
        `CHK(re, 1'b1)
        dma_tx_valid[2] <= 1'b1;
        dma_tx_data[23:16] <= 8'h96;
        `WAITQ(dma_tx_ready[2])
        dma_tx_valid[2] <= 1'b0;
        `WAITQ(dma_rx_valid[2])
        `CHK(dma_rx_data[23:16], 8'h69)
        dma_rx_ready[2] <= 1'b1;
        @(posedge ref_clk);
        dma_rx_ready[2] <= 1'b0;
        idle(8'h40);
        `CHK(mrx, 8'h96)
        $display("port a dma test done");
        apb(1, 8'h60, 32'h09);
        apb(1, 8'h68, 32'h5A);
        apb(1, 8'h68, 32'hC3);
        idle(8'h60);
        `CHK(snf, 16'h5AC3)
        apb(1, 8'h00, 32'h1D);
        apb(1, 8'h08, 32'h81);
        idle(8'h00);
        apb(0, 8'h0C, 0);
        `CHK(rq, 32'h81)
        $display("port b and memory port test done");
        apb(1, 8'h60, 32'h83);
        apb(1, 8'h68, 32'h3E);
        slv <= 1'b1;
        tcs <= 1'b0;
        repeat (4) @(posedge ref_clk);
        // link clock: 80 ns period, with chip select already low
        for (m = 7; m >= 0; m--) begin
            mosi <= sb[m];
            repeat (4) @(posedge ref_clk);
            tsclk <= 1'b1;
            rb[m] = dq_o[25];
            repeat (4) @(posedge ref_clk);
            tsclk <= 1'b0;
        end
        repeat (4) @(posedge ref_clk);
        tcs <= 1'b1;
        repeat (8) @(posedge ref_clk);
        `CHK(rb, 8'h3E)
        apb(0, 8'h6C, 0);
        `CHK(rq, 32'hB4)
        $display("port b slave test done");
        results;
    end
endmodule // tb_top
